// ==== port_flow_control_config.sv ====
`default_nettype none
// Contract
// (RQ1) bit 6 enables half-duplex backpressure
// (RQ2) bit 5 reads duplex, 1 half
// (RQ3) bit 4 reads receive pause in force
// (RQ4) bit 3 reads transmit pause in force
// (RQ5) bit 2 receive pause when manual
// (RQ6) bit 1 transmit pause when manual
// (RQ7) bit 0 clear: autoneg result decides; here only while autoneg is on, with autoneg off the manual enables decide
// (RQ8) bit 0 set: manual enables decide
// (RQ9) writable defaults come from straps, reloadable
// (RQ10) status resets from combined strap settings
// (RQ11) status shows settings actually in force
// (RQ12) writes leave PHY advertisement untouched
// (RQ13) pause source address from station registers
// (RQ14) upper bits zero; half duplex zeroes pause
module port_flow_control_config
   import fc_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   // register port
   // no wait states: a read answers on the next edge
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [DATA_W-1:0] reg_rdata,
   // configuration straps, from pins
   // levels, taken in only once after each reset
   input wire logic backpressure_strap,
   input wire logic pause_enable_strap,
   input wire logic manual_select_strap,
   input wire logic autoneg_strap,
   input wire logic half_duplex_strap,
   // eeprom loader rewrite of the straps
   // a one-cycle pulse on this clock, with the values beside it
   input wire logic loader_strap_write,
   input wire logic loader_backpressure,
   input wire logic loader_pause_enable,
   input wire logic loader_manual_select,
   // link state from the port phy, from another domain
   // negotiated levels, slow to change
   input wire logic link_half_duplex,
   input wire logic an_rx_pause,
   input wire logic an_tx_pause,
   // to the port mac
   // levels that change only on a clock edge
   output logic backpressure_enable,
   output logic mac_rx_pause_enable,
   output logic mac_tx_pause_enable,
   output logic [47:0] pause_source_addr
);
   // stored writable fields
   // each field has one process; whichever of strap load, loader
   // rewrite and software write reach it are ranked inside it
   logic backpressure_reg; // half duplex backpressure
   logic rx_pause_reg; // manual receive pause
   logic tx_pause_reg; // manual transmit pause
   logic manual_reg; // manual select
   logic autoneg_en_reg; // autoneg enable
   logic force_half_reg; // forced half duplex when autoneg off
   logic [31:0] addr_low_reg; // station address low
   logic [15:0] addr_high_reg; // station address high
   logic [31:0] rdata_reg; // read data register
   // status registers, effective values
   // what the port really does, not what software asked for
   logic cur_duplex_reg;
   logic cur_rx_reg;
   logic cur_tx_reg;
   // strap load machine
   // runs once after each reset, then rests in its last state
   strap_state_e state_reg;
   strap_state_e state_next;
   // set one edge after release, lets the strap synchroniser refill
   logic idle_wait_reg;
   // synchronised pins
   // named after the second flop; nothing reads the first
   logic [4:0] strap_sync;
   logic [2:0] link_sync;
   logic strap_bp;
   logic strap_pause;
   logic strap_manual;
   logic strap_an;
   logic strap_half;
   logic link_half;
   logic link_an_rx;
   logic link_an_tx;
   // address decode
   logic hit_flow;
   logic hit_low;
   logic hit_high;
   logic hit_ctrl;
   logic wr_flow;
   logic wr_low;
   logic wr_high;
   logic wr_ctrl;
   logic load_straps;
   // resolved flow control
   // duplex and pause in force, ahead of the status registers
   logic half_now;
   logic eff_rx;
   logic eff_tx;
   logic [31:0] flow_word;
   logic [31:0] ctrl_word;
   logic [31:0] rdata_next;

   // straps cross in through two flops
   // both stages clear under reset, so the second stage shows
   // the pins only from the second edge after release; the load
   // machine below waits for that before it samples them, or
   // every strap field would come up zero
   fc_sync2 #(
      .WIDTH(5)
   ) strap_sync_i (
      .clock(clock),
      .rst_n(rst_n),
      .async_in({backpressure_strap, pause_enable_strap, manual_select_strap,
                 autoneg_strap, half_duplex_strap}),
      .sync_out(strap_sync)
   );
   // phy link state crosses in through two flops
   // a change on these pins shows up in the status bits
   // three edges after the pin moves
   fc_sync2 #(
      .WIDTH(3)
   ) link_sync_i (
      .clock(clock),
      .rst_n(rst_n),
      .async_in({link_half_duplex, an_rx_pause, an_tx_pause}),
      .sync_out(link_sync)
   );
   // unpack in the order the pins were packed
   assign {strap_bp, strap_pause, strap_manual, strap_an, strap_half} = strap_sync;
   assign {link_half, link_an_rx, link_an_tx} = link_sync;

   // strap load sequencing
   // idle until the synchroniser holds the pins, sample once,
   // then run; register writes to the strap fields are refused
   // until run so that a strap load never overwrites them
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         // wait for synchronisers to fill
         LOAD_IDLE: begin
            // second stage is full from the edge that leaves idle
            if (idle_wait_reg) begin
               state_next = LOAD_SAMPLE;
            end
         end
         // one cycle to capture straps
         // the field processes take the synchronised pins now
         LOAD_SAMPLE: begin
            state_next = LOAD_RUN;
         end
         // normal operation
         // stays here until the next reset
         LOAD_RUN: begin
            state_next = LOAD_RUN;
         end
         // illegal code: restart the load
         default: begin
            state_next = LOAD_IDLE;
         end
      endcase
   end
   // state register
   // a corrupted code falls back to idle through the default
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         state_reg <= LOAD_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end
   // wait flag, one edge after release
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         // low through reset
         idle_wait_reg <= 1'b0;
      end else begin
         // up from the first edge after release
         idle_wait_reg <= 1'b1;
      end
   end
   // straps are sampled after release, not under reset
   // a pin that changes later is not seen again; only the
   // loader rewrite can move these fields without software
   assign load_straps = (state_reg == LOAD_SAMPLE); // RQ9

   // address decode
   // full byte address compare, so no register has an alias;
   // anything else reads as zero and swallows writes
   assign hit_flow = (reg_addr == FLOW_CTRL_OFFSET);
   assign hit_low = (reg_addr == STATION_ADDR_LOW_OFFSET);
   assign hit_high = (reg_addr == STATION_ADDR_HIGH_OFFSET);
   assign hit_ctrl = (reg_addr == PORT_CTRL_OFFSET);
   // writes only once the straps are in
   // station address writes need no guard: no strap feeds them
   assign wr_flow = reg_write & hit_flow & (state_reg == LOAD_RUN);
   assign wr_low = reg_write & hit_low;
   assign wr_high = reg_write & hit_high;
   assign wr_ctrl = reg_write & hit_ctrl & (state_reg == LOAD_RUN);

   // backpressure field: strap, loader, then software
   // the loader rewrite beats a coincident software write, so
   // a configuration load cannot be half undone by the host;
   // the field goes to the mac ungated, in either duplex
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         backpressure_reg <= 1'b0;
      end else if (load_straps) begin
         backpressure_reg <= strap_bp; // RQ9
      end else if (loader_strap_write) begin
         backpressure_reg <= loader_backpressure; // RQ9
      end else if (wr_flow) begin
         backpressure_reg <= reg_wdata[BACKPRESSURE_BIT]; // RQ1
      end
   end
   // manual pause enables and select
   // one pause strap seeds both directions; software may then
   // set receive and transmit apart; with autoneg on, the select bit decides
   // whether these enables or the negotiated result govern
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         rx_pause_reg <= 1'b0;
         tx_pause_reg <= 1'b0;
         manual_reg <= 1'b0;
      end else if (load_straps) begin
         rx_pause_reg <= strap_pause; // RQ9
         tx_pause_reg <= strap_pause; // RQ9
         manual_reg <= strap_manual; // RQ9
      end else if (loader_strap_write) begin
         rx_pause_reg <= loader_pause_enable; // RQ9
         tx_pause_reg <= loader_pause_enable; // RQ9
         manual_reg <= loader_manual_select; // RQ9
      end else if (wr_flow) begin
         rx_pause_reg <= reg_wdata[RX_PAUSE_BIT]; // RQ5
         tx_pause_reg <= reg_wdata[TX_PAUSE_BIT]; // RQ6
         manual_reg <= reg_wdata[MANUAL_SEL_BIT]; // RQ7
      end
   end
   // port control: autoneg enable and forced duplex
   // forced duplex only matters while autoneg is off; with it
   // on, the negotiated duplex from the link pins is used;
   // turning autoneg off also hands pause to the manual enables
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         autoneg_en_reg <= AUTONEG_EN_RESET;
         force_half_reg <= FORCE_HALF_RESET;
      end else if (load_straps) begin
         autoneg_en_reg <= strap_an;
         force_half_reg <= strap_half;
      end else if (wr_ctrl) begin
         autoneg_en_reg <= reg_wdata[AUTONEG_EN_BIT];
         force_half_reg <= reg_wdata[FORCE_HALF_BIT];
      end
   end
   // station address for pause frame source
   // the high word keeps only sixteen bits; the rest of a
   // write there is dropped and reads back as zero
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         addr_low_reg <= STATION_ADDR_LOW_RESET;
         addr_high_reg <= STATION_ADDR_HIGH_RESET;
      end else begin
         if (wr_low) begin
            addr_low_reg <= reg_wdata; // RQ13
         end
         if (wr_high) begin
            addr_high_reg <= reg_wdata[15:0]; // RQ13
         end
      end
   end

   // duplex: negotiated when autoneg on, else forced
   // a link that drops to half duplex zeroes both pause bits
   assign half_now = autoneg_en_reg ? link_half : force_half_reg; // RQ2 RQ10
   // pause resolution
   // kept in its own module so the choice between manual
   // enables and negotiated result sits in one place;
   // it is pure logic, the status registers below time it
   fc_resolve resolve_i (
      .manual_sel(manual_reg),
      .autoneg_en(autoneg_en_reg),
      .half_duplex(half_now),
      .rx_pause_enable(rx_pause_reg),
      .tx_pause_enable(tx_pause_reg),
      .an_rx_pause(link_an_rx),
      .an_tx_pause(link_an_tx),
      .eff_rx_pause(eff_rx),
      .eff_tx_pause(eff_tx)
   );
   // status follows the combined straps and link state
   // registered so that a read and the mac outputs see one value;
   // after reset these settle one edge after the strap load,
   // so their reset value comes from several straps together
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         cur_duplex_reg <= 1'b0;
         cur_rx_reg <= 1'b0;
         cur_tx_reg <= 1'b0;
      end else begin
         cur_duplex_reg <= half_now; // RQ2 RQ10
         cur_rx_reg <= eff_rx; // RQ3 RQ11
         cur_tx_reg <= eff_tx; // RQ4 RQ11
      end
   end

   // read word assembly, upper bits zero
   // status bits 5 to 3 are read only; a write to them is ignored
   assign flow_word = {25'h0000000, backpressure_reg, cur_duplex_reg, cur_rx_reg,
                       cur_tx_reg, rx_pause_reg, tx_pause_reg, manual_reg}; // RQ14
   // port control word: bit 1 forced half, bit 0 autoneg
   assign ctrl_word = {30'h00000000, force_half_reg, autoneg_en_reg};
   // read mux
   // the hits are exclusive, so the chain order is harmless
   assign rdata_next = hit_flow ? flow_word :
                       hit_low ? addr_low_reg :
                       hit_high ? {16'h0000, addr_high_reg} :
                       hit_ctrl ? ctrl_word :
                       UNMAPPED_DATA;
   // read data register, valid one cycle after strobe
   // it returns to zero in every cycle without a read, so a
   // stale word can never be mistaken for an answer; reads
   // have no side effect, so back to back reads are safe
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         rdata_reg <= '0;
      end else if (reg_read) begin
         rdata_reg <= rdata_next;
      end else begin
         rdata_reg <= '0;
      end
   end
   assign reg_rdata = rdata_reg;

   // outputs to the mac; no path to the phy advertisement exists
   // the mac sees the effective pause, not the manual enables,
   // so a half duplex link never sends or honours pause frames;
   // the station address goes out as written, high word first
   assign backpressure_enable = backpressure_reg; // RQ1 RQ12
   assign mac_rx_pause_enable = cur_rx_reg; // RQ11
   assign mac_tx_pause_enable = cur_tx_reg; // RQ11
   assign pause_source_addr = {addr_high_reg, addr_low_reg}; // RQ13
endmodule : port_flow_control_config
`default_nettype wire

// ==== fc_pkg.sv ====
`default_nettype none
package fc_pkg;
   // register bus geometry
   localparam int unsigned ADDR_W = 12;
   localparam int unsigned DATA_W = 32;
   // register offsets (byte addresses)
   localparam logic [11:0] FLOW_CTRL_OFFSET = 12'h1a0;
   localparam logic [11:0] STATION_ADDR_LOW_OFFSET = 12'h1ac;
   localparam logic [11:0] STATION_ADDR_HIGH_OFFSET = 12'h1b0;
   localparam logic [11:0] PORT_CTRL_OFFSET = 12'h1b4;
   // flow control register field positions
   localparam int unsigned BACKPRESSURE_BIT = 6;
   localparam int unsigned CUR_DUPLEX_BIT = 5;
   localparam int unsigned CUR_RX_PAUSE_BIT = 4;
   localparam int unsigned CUR_TX_PAUSE_BIT = 3;
   localparam int unsigned RX_PAUSE_BIT = 2;
   localparam int unsigned TX_PAUSE_BIT = 1;
   localparam int unsigned MANUAL_SEL_BIT = 0;
   // port control register field positions
   localparam int unsigned AUTONEG_EN_BIT = 0;
   localparam int unsigned FORCE_HALF_BIT = 1;
   // reset values of station address and port control fields
   localparam logic [31:0] STATION_ADDR_LOW_RESET = 32'h00000000;
   localparam logic [15:0] STATION_ADDR_HIGH_RESET = 16'h0000;
   localparam logic AUTONEG_EN_RESET = 1'b1;
   localparam logic FORCE_HALF_RESET = 1'b0;
   // read answer for unmapped addresses
   localparam logic [31:0] UNMAPPED_DATA = 32'h00000000;
   // strap loader state machine, one-hot
   typedef enum logic [2:0] {
      LOAD_IDLE = 3'b001,
      LOAD_SAMPLE = 3'b010,
      LOAD_RUN = 3'b100
   } strap_state_e;
endpackage : fc_pkg
`default_nettype wire

// ==== fc_sync2.sv ====
`default_nettype none
// two flip-flop synchroniser, per bit
module fc_sync2
   import fc_pkg::*;
#(
   parameter int unsigned WIDTH = 1
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_reg; // first stage, read only by second
   logic [WIDTH-1:0] sync_reg; // second stage
   // both stages clear on reset
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         meta_reg <= '0;
         sync_reg <= '0;
      end else begin
         meta_reg <= async_in;
         sync_reg <= meta_reg;
      end
   end
   assign sync_out = sync_reg;
endmodule : fc_sync2
`default_nettype wire

// ==== fc_resolve.sv ====
`default_nettype none
// resolves the flow control actually in force
module fc_resolve
   import fc_pkg::*;
(
   input wire logic manual_sel,
   input wire logic autoneg_en,
   input wire logic half_duplex,
   input wire logic rx_pause_enable,
   input wire logic tx_pause_enable,
   input wire logic an_rx_pause,
   input wire logic an_tx_pause,
   output logic eff_rx_pause,
   output logic eff_tx_pause
);
   logic use_manual; // manual enables govern
   // manual wins when selected or autoneg off
   assign use_manual = manual_sel | ~autoneg_en; // RQ5 RQ6 RQ7 RQ8
   // pause only in full duplex
   assign eff_rx_pause = ~half_duplex &
      (use_manual ? rx_pause_enable : an_rx_pause); // RQ7 RQ14
   assign eff_tx_pause = ~half_duplex &
      (use_manual ? tx_pause_enable : an_tx_pause); // RQ7 RQ14
endmodule : fc_resolve
`default_nettype wire

// ==== port_flow_control_properties.sv ====
`default_nettype none
// port-level checks of the flow control register block
module port_flow_control_checker
   import fc_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [DATA_W-1:0] reg_rdata,
   input wire logic loader_strap_write,
   input wire logic loader_backpressure,
   input wire logic backpressure_enable,
   input wire logic mac_rx_pause_enable,
   input wire logic mac_tx_pause_enable,
   input wire logic [47:0] pause_source_addr
);
   logic [1:0] run_cnt; // edges since release, saturating
   wire logic fc_rd = reg_read && reg_addr == FLOW_CTRL_OFFSET;
   wire logic run = run_cnt == 2'h3; // strap load over
   wire logic fc_wr = reg_write && reg_addr == FLOW_CTRL_OFFSET && run && !loader_strap_write;
   wire logic bp_bit = reg_wdata[BACKPRESSURE_BIT];
   wire logic mapped = reg_addr inside {FLOW_CTRL_OFFSET, STATION_ADDR_LOW_OFFSET,
      STATION_ADDR_HIGH_OFFSET, PORT_CTRL_OFFSET};
   // waits out the strap load, writes before it are dropped
   always_ff @(posedge clock) begin
      if (!rst_n)
         run_cnt <= 2'h0;
      else if (!run)
         run_cnt <= run_cnt + 2'h1;
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   a_read_idle: assert property (!$past(reg_read) |-> reg_rdata == 32'h0)
      else $error("read data not zero outside answer");
   a_upper_zero: assert property (fc_rd |=> reg_rdata[31:7] == 25'h0)
      else $error("reserved bits not zero");
   a_half_quiet: assert property (fc_rd ##1 reg_rdata[5] |-> reg_rdata[4:3] == 2'h0)
      else $error("pause shown in half duplex");
   a_bp_readback: assert property (fc_rd |=> reg_rdata[6] == $past(backpressure_enable))
      else $error("backpressure readback wrong");
   a_rx_readback: assert property (fc_rd |=> reg_rdata[4] == $past(mac_rx_pause_enable))
      else $error("rx pause status wrong");
   a_tx_readback: assert property (fc_rd |=> reg_rdata[3] == $past(mac_tx_pause_enable))
      else $error("tx pause status wrong");
   a_bp_write: assert property (fc_wr |=> backpressure_enable == $past(bp_bit))
      else $error("backpressure write lost");
   a_loader_bp: assert property (loader_strap_write && run |=>
      backpressure_enable == $past(loader_backpressure))
      else $error("loader rewrite lost");
   a_station_low: assert property (reg_write && reg_addr == STATION_ADDR_LOW_OFFSET |=>
      pause_source_addr[31:0] == $past(reg_wdata))
      else $error("station address low wrong");
   a_unmapped_zero: assert property (reg_read && !mapped |=> reg_rdata == 32'h0)
      else $error("unmapped read not zero");
   c_manual: cover property (fc_wr ##1 mac_rx_pause_enable);
   c_half: cover property (fc_rd ##1 reg_rdata[5]);
   c_loader: cover property (loader_strap_write && run);
endmodule : port_flow_control_checker
`default_nettype wire

// ==== fc_link_partner.sv ====
`default_nettype none
// phy side: negotiated duplex and pause, set by the bench
module fc_link_partner (
   input wire logic clock,
   input wire logic [2:0] link_cmd,
   output logic link_half_duplex,
   output logic an_rx_pause,
   output logic an_tx_pause
);
   // link state changes just after an edge, like a real phy register
   always_ff @(posedge clock) begin
      {link_half_duplex, an_rx_pause, an_tx_pause} <= link_cmd;
   end
endmodule : fc_link_partner
`default_nettype wire

// ==== port_flow_control_config_tb.sv ====
`default_nettype none
module port_flow_control_config_tb
   import fc_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic [ADDR_W-1:0] reg_addr = 12'h000;
   logic [DATA_W-1:0] reg_wdata = 32'h0, reg_rdata;
   logic reg_write = 1'b0, reg_read = 1'b0;
   // straps: backpressure and pause on, autoneg on, full duplex
   logic backpressure_strap = 1'b1, pause_enable_strap = 1'b1, manual_select_strap = 1'b0;
   logic autoneg_strap = 1'b1, half_duplex_strap = 1'b0;
   logic loader_strap_write = 1'b0, loader_backpressure = 1'b0;
   logic loader_pause_enable = 1'b0, loader_manual_select = 1'b0;
   logic link_half_duplex, an_rx_pause, an_tx_pause;
   logic [2:0] link_cmd = 3'h2; // full duplex, rx pause only
   logic backpressure_enable, mac_rx_pause_enable, mac_tx_pause_enable;
   logic [47:0] pause_source_addr;
   int errors = 0;
   int check_count = 0;
   int cycles = 0;
   always #12.5 clock = ~clock;
   port_flow_control_config i_dut (.clock, .rst_n, .reg_addr, .reg_wdata, .reg_write,
      .reg_read, .reg_rdata, .backpressure_strap, .pause_enable_strap, .manual_select_strap,
      .autoneg_strap, .half_duplex_strap, .loader_strap_write, .loader_backpressure,
      .loader_pause_enable, .loader_manual_select, .link_half_duplex, .an_rx_pause,
      .an_tx_pause, .backpressure_enable, .mac_rx_pause_enable, .mac_tx_pause_enable,
      .pause_source_addr);
   fc_link_partner i_link (.clock, .link_cmd, .link_half_duplex, .an_rx_pause, .an_tx_pause);
   task automatic finish_test();
      if (errors == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : finish_test
   task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
      check_count++;
      if (seen !== exp) begin
         errors++;
         $display("FAIL %s exp %h seen %h", what, exp, seen);
      end
   endtask : check
   // one write strobe, then three quiet cycles
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clock);
      reg_write <= 1'b0;
      repeat (3) @(posedge clock);
   endtask : wr
   // read data is looked at in its single answer cycle
   task automatic rd_check(input string what, input logic [11:0] a, input logic [31:0] exp);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clock);
      reg_read <= 1'b0;
      #1;
      check(what, {16'h0, reg_rdata}, {16'h0, exp});
      @(posedge clock);
   endtask : rd_check
   task automatic link(input logic [2:0] c);
      link_cmd <= c;
      repeat (6) @(posedge clock);
   endtask : link
   task automatic test_defaults();
      rd_check("flow reset", FLOW_CTRL_OFFSET, 32'h56);
      rd_check("port reset", PORT_CTRL_OFFSET, 32'h1);
      check("bp out", backpressure_enable, 1'b1);
   endtask : test_defaults
   task automatic test_autoneg();
      link(3'h1);
      rd_check("autoneg", FLOW_CTRL_OFFSET, 32'h4e);
      check("an pause", {mac_rx_pause_enable, mac_tx_pause_enable}, 2'h1);
   endtask : test_autoneg
   task automatic test_manual();
      wr(FLOW_CTRL_OFFSET, 32'hffffffbd);
      rd_check("manual", FLOW_CTRL_OFFSET, 32'h15);
      check("bp off", backpressure_enable, 1'b0);
      check("man pause", {mac_rx_pause_enable, mac_tx_pause_enable}, 2'h2);
   endtask : test_manual
   task automatic test_half();
      link(3'h7);
      rd_check("half", FLOW_CTRL_OFFSET, 32'h25);
      check("half pause", {mac_rx_pause_enable, mac_tx_pause_enable}, 2'h0);
      link(3'h0);
   endtask : test_half
   task automatic test_autoneg_off();
      wr(FLOW_CTRL_OFFSET, 32'h2);
      wr(PORT_CTRL_OFFSET, 32'h0);
      rd_check("an off", FLOW_CTRL_OFFSET, 32'h0a);
      wr(PORT_CTRL_OFFSET, 32'h2);
      rd_check("forced half", FLOW_CTRL_OFFSET, 32'h22);
   endtask : test_autoneg_off
   task automatic test_loader();
      loader_backpressure <= 1'b1;
      loader_pause_enable <= 1'b1;
      loader_manual_select <= 1'b1;
      loader_strap_write <= 1'b1;
      @(posedge clock);
      loader_strap_write <= 1'b0;
      repeat (3) @(posedge clock);
      rd_check("loader", FLOW_CTRL_OFFSET, 32'h67);
   endtask : test_loader
   task automatic test_station();
      wr(STATION_ADDR_LOW_OFFSET, 32'h89abcdef);
      wr(STATION_ADDR_HIGH_OFFSET, 32'h00000123);
      check("station", pause_source_addr, 48'h012389abcdef);
      rd_check("station low", STATION_ADDR_LOW_OFFSET, 32'h89abcdef);
      rd_check("unmapped", 12'h1a4, 32'h0);
   endtask : test_station
   // straps moved and reset pulsed in mid run
   task automatic test_restrap();
      backpressure_strap <= 1'b0;
      manual_select_strap <= 1'b1;
      autoneg_strap <= 1'b0;
      half_duplex_strap <= 1'b1;
      rst_n <= 1'b0;
      repeat (5) @(posedge clock);
      check("reset bp", backpressure_enable, 1'b0);
      check("reset station", pause_source_addr, 48'h0);
      rst_n <= 1'b1;
      repeat (6) @(posedge clock);
      rd_check("restrap flow", FLOW_CTRL_OFFSET, 32'h27);
      rd_check("restrap port", PORT_CTRL_OFFSET, 32'h2);
      check("restrap pause", {mac_rx_pause_enable, mac_tx_pause_enable}, 2'h0);
   endtask : test_restrap
   // hang guard
   always @(posedge clock) begin
      cycles++;
      if (cycles == 2000) begin
         errors++;
         finish_test();
      end
   end
   initial begin
      repeat (5) @(posedge clock);
      rst_n <= 1'b1;
      repeat (6) @(posedge clock);
      test_defaults();
      test_autoneg();
      test_manual();
      test_half();
      test_autoneg_off();
      test_loader();
      test_station();
      test_restrap();
      finish_test();
   end
endmodule : port_flow_control_config_tb
bind port_flow_control_config port_flow_control_checker i_chk (.clock, .rst_n, .reg_addr,
   .reg_wdata, .reg_write, .reg_read, .reg_rdata, .loader_strap_write, .loader_backpressure,
   .backpressure_enable, .mac_rx_pause_enable, .mac_tx_pause_enable, .pause_source_addr);
`default_nettype wire
